// *** logic/sbmr_pkg.sv ***
// ************************************************************
// Constants of the buffer manager register group
// ************************************************************
package sbmr_pkg;

  // ************************************************************
  // Bus and map
  // ************************************************************
  localparam int ADDR_W = 16;
  localparam int IDX_W = 14;
  localparam int IDX_LSB = 2;
  localparam int NUM_PORTS = 3;
  localparam int NUM_QUEUES = 4;
  localparam logic [13:0] IDX_P2_RATE_Q01 = 14'h1c11;
  localparam logic [13:0] IDX_P2_RATE_Q23 = 14'h1c12;
  localparam logic [2:0][13:0] IDX_DEFAULT_TAG = {14'h1c15, 14'h1c14, 14'h1c13};
  localparam logic [2:0][13:0] IDX_DROP_CNT = {14'h1c18, 14'h1c17, 14'h1c16};
  localparam logic [13:0] IDX_IRQ_MASK = 14'h1c20;
  localparam logic [13:0] IDX_IRQ_PENDING = 14'h1c21;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Field layouts, write masks and reset values
  // ************************************************************
  localparam int RATE_W = 13;
  localparam int RATE_LO_LSB = 0;
  localparam int RATE_HI_LSB = 13;
  localparam int VID_LSB = 0;
  localparam int VID_W = 12;
  localparam int PRIO_LSB = 12;
  localparam int PRIO_W = 3;
  localparam int MASK_BIT = 0;
  localparam logic [31:0] RATE_WMASK = 32'h03ff_ffff;
  localparam logic [31:0] TAG_WMASK = 32'h0000_7fff;
  localparam logic [31:0] MASK_WMASK = 32'h0000_0001;
  localparam logic [31:0] RATE_RESET = 32'h0000_0000;
  localparam logic [31:0] TAG_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0001;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;
  localparam logic [31:0] CNT_MAX = 32'hffff_ffff;

  // Pending register: two capture slots
  localparam int PEND_A_VALID = 0;
  localparam int PEND_A_PORT_LSB = 1;
  localparam int PEND_A_REASON_LSB = 3;
  localparam int PEND_B_VALID = 7;
  localparam int PEND_B_PORT_LSB = 8;
  localparam int PEND_B_REASON_LSB = 10;
  localparam logic [3:0] REASON_RED = 4'h1;
  localparam logic [3:0] REASON_YELLOW = 4'h9;

  // ************************************************************
  // Egress pacing timing
  // ************************************************************
  localparam int BYTE_UNIT_NS = 20;
  localparam int CLK_PERIOD_NS = 20;
  localparam int UNIT_CYCLES = (BYTE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PACE_W = 16;
  localparam logic [15:0] PACE_ONE = 16'h0001;
  localparam logic [15:0] PACE_ZERO = 16'h0000;

  typedef enum logic {
    SBMR_PACE_IDLE,
    SBMR_PACE_WAIT
  } sbmr_pace_state_t;

endpackage

// *** logic/sbmr_pacer.sv ***
`timescale 1ns/1ps
// ************************************************************
// One egress queue pacer
// ************************************************************
module sbmr_pacer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Rate setting and byte handshake
  input wire logic [12:0] rate,
  input wire logic byte_sent,
  output logic ready
);

  sbmr_pkg::sbmr_pace_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] load;

  // Gap is (rate + 1) units of 20 ns
  assign load = 16'((({3'h0, rate} + sbmr_pkg::PACE_ONE) *
                16'(sbmr_pkg::UNIT_CYCLES)) - sbmr_pkg::PACE_ONE);
  assign ready = (state_reg == sbmr_pkg::SBMR_PACE_IDLE);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      sbmr_pkg::SBMR_PACE_IDLE: begin
        if (byte_sent) begin
          cnt_next = load;
          state_next = sbmr_pkg::SBMR_PACE_WAIT;
        end
      end
      sbmr_pkg::SBMR_PACE_WAIT: begin
        if (cnt_reg == sbmr_pkg::PACE_ZERO) begin
          state_next = sbmr_pkg::SBMR_PACE_IDLE;
        end else begin
          cnt_next = cnt_reg - sbmr_pkg::PACE_ONE;
        end
      end
      default: begin
        state_next = sbmr_pkg::SBMR_PACE_IDLE;
        cnt_next = sbmr_pkg::PACE_ZERO;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= sbmr_pkg::SBMR_PACE_IDLE;
      cnt_reg <= sbmr_pkg::PACE_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule

// *** logic/sbmr_top.sv ***
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// ************************************************************
// Buffer manager register group with AXI4-Lite slave
// ************************************************************
// Summary of operation
// - Each 13-bit egress rate field holds a queue's ready low for (value + 1) x 20 ns after each byte.
// - Each port holds a 3-bit default priority in bits 14:12 used for egress tagging.
// - Each port holds a 12-bit default VLAN ID in bits 11:0 used for egress tagging.
// - Ports 0, 1 and 2 each have their own default tag register, affecting only that port.
// - A per-port 32-bit counter counts packets dropped by ingress rate limiting.
// - Reading a drop counter returns its value and then clears it.
// - A drop counter stops at all ones and never wraps.
// - Mask bit 0 blocks all buffer manager interrupts and resets to one.
// - Clearing the mask bit lets pending status drive the interrupt output.
// - The mask never changes how drop events are captured as pending status.
// - Pending status has two capture slots, each with reason and source port.
module sbmr_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Drop events from the buffer manager
  input wire logic drop_valid,
  input wire logic [3:0] drop_reason,
  input wire logic [1:0] drop_port,
  // Port 2 egress queue pacing
  input wire logic [3:0] p2_byte_sent,
  output logic [3:0] p2_queue_ready,
  // Default tag values per port
  output logic [11:0] port0_default_vid,
  output logic [2:0] port0_default_prio,
  output logic [11:0] port1_default_vid,
  output logic [2:0] port1_default_prio,
  output logic [11:0] port2_default_vid,
  output logic [2:0] port2_default_prio,
  // Interrupt
  output logic irq
);

  // ************************************************************
  // State
  // ************************************************************
  logic aw_have_reg, aw_have_next;
  logic [13:0] aw_idx_reg, aw_idx_next;
  logic w_have_reg, w_have_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rate_q01_reg, rate_q01_next;
  logic [31:0] rate_q23_reg, rate_q23_next;
  logic [31:0] tag_reg [3];
  logic [31:0] tag_next [3];
  logic [31:0] cnt_reg [3];
  logic [31:0] cnt_next [3];
  logic [31:0] mask_reg, mask_next;
  logic a_valid_reg, a_valid_next;
  logic [1:0] a_port_reg, a_port_next;
  logic [3:0] a_reason_reg, a_reason_next;
  logic b_valid_reg, b_valid_next;
  logic [1:0] b_port_reg, b_port_next;
  logic [3:0] b_reason_reg, b_reason_next;

  logic wr_fire;
  logic rd_take;
  logic [13:0] ar_idx;
  logic rate_drop;
  logic [31:0] pend_word;
  logic [12:0] q_rate [4];

  // Byte-lane merge, reserved bits held at zero
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & wmask;
  endfunction

  // ************************************************************
  // Handshakes and combinational outputs
  // ************************************************************
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign rd_take = s_axi_arvalid && !rvalid_reg;
  assign ar_idx = s_axi_araddr[sbmr_pkg::ADDR_W-1:sbmr_pkg::IDX_LSB];
  assign rate_drop = drop_valid && ((drop_reason == sbmr_pkg::REASON_RED) ||
                     (drop_reason == sbmr_pkg::REASON_YELLOW));

  assign pend_word = {18'h0_0000, b_reason_reg, b_port_reg, b_valid_reg,
                      a_reason_reg, a_port_reg, a_valid_reg};

  // Pending status reaches the pin only while the mask bit is clear
  assign irq = !mask_reg[sbmr_pkg::MASK_BIT] && (a_valid_reg || b_valid_reg);

  // Each port sees only its own register
  assign port0_default_vid = tag_reg[0][sbmr_pkg::VID_LSB +: sbmr_pkg::VID_W];
  assign port0_default_prio = tag_reg[0][sbmr_pkg::PRIO_LSB +: sbmr_pkg::PRIO_W];
  assign port1_default_vid = tag_reg[1][sbmr_pkg::VID_LSB +: sbmr_pkg::VID_W];
  assign port1_default_prio = tag_reg[1][sbmr_pkg::PRIO_LSB +: sbmr_pkg::PRIO_W];
  assign port2_default_vid = tag_reg[2][sbmr_pkg::VID_LSB +: sbmr_pkg::VID_W];
  assign port2_default_prio = tag_reg[2][sbmr_pkg::PRIO_LSB +: sbmr_pkg::PRIO_W];

  // ************************************************************
  // Egress pacers, one per queue
  // ************************************************************
  assign q_rate[0] = rate_q01_reg[sbmr_pkg::RATE_LO_LSB +: sbmr_pkg::RATE_W];
  assign q_rate[1] = rate_q01_reg[sbmr_pkg::RATE_HI_LSB +: sbmr_pkg::RATE_W];
  assign q_rate[2] = rate_q23_reg[sbmr_pkg::RATE_LO_LSB +: sbmr_pkg::RATE_W];
  assign q_rate[3] = rate_q23_reg[sbmr_pkg::RATE_HI_LSB +: sbmr_pkg::RATE_W];

  // Separate counters, so no queue shares timing with another
  for (genvar q = 0; q < sbmr_pkg::NUM_QUEUES; q++) begin : g_pace
    sbmr_pacer u_pacer (
      .aclk(aclk),
      .aresetn(aresetn),
      .rate(q_rate[q]),
      .byte_sent(p2_byte_sent[q]),
      .ready(p2_queue_ready[q])
    );
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic hit;
    logic take_a;
    hit = 1'b0;
    take_a = 1'b0;
    aw_have_next = aw_have_reg;
    aw_idx_next = aw_idx_reg;
    w_have_next = w_have_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    rate_q01_next = rate_q01_reg;
    rate_q23_next = rate_q23_reg;
    mask_next = mask_reg;
    a_valid_next = a_valid_reg;
    a_port_next = a_port_reg;
    a_reason_next = a_reason_reg;
    b_valid_next = b_valid_reg;
    b_port_next = b_port_reg;
    b_reason_next = b_reason_reg;
    for (int p = 0; p < sbmr_pkg::NUM_PORTS; p++) begin
      tag_next[p] = tag_reg[p];
      cnt_next[p] = cnt_reg[p];
    end

    // Write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      aw_idx_next = s_axi_awaddr[sbmr_pkg::ADDR_W-1:sbmr_pkg::IDX_LSB];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end

    // Register write once both halves are held
    if (wr_fire) begin
      hit = 1'b1;
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      if (aw_idx_reg == sbmr_pkg::IDX_P2_RATE_Q01) begin
        rate_q01_next = merge(rate_q01_reg, w_data_reg, w_strb_reg, sbmr_pkg::RATE_WMASK);
      end else if (aw_idx_reg == sbmr_pkg::IDX_P2_RATE_Q23) begin
        rate_q23_next = merge(rate_q23_reg, w_data_reg, w_strb_reg, sbmr_pkg::RATE_WMASK);
      end else if (aw_idx_reg == sbmr_pkg::IDX_IRQ_MASK) begin
        mask_next = merge(mask_reg, w_data_reg, w_strb_reg, sbmr_pkg::MASK_WMASK);
      end else if (aw_idx_reg == sbmr_pkg::IDX_IRQ_PENDING) begin
        // Write one to a slot's valid bit to free it
        if (w_strb_reg[0] && w_data_reg[sbmr_pkg::PEND_A_VALID]) begin
          a_valid_next = 1'b0;
        end
        if (w_strb_reg[0] && w_data_reg[sbmr_pkg::PEND_B_VALID]) begin
          b_valid_next = 1'b0;
        end
      end else begin
        hit = 1'b0;
        for (int p = 0; p < sbmr_pkg::NUM_PORTS; p++) begin
          if (aw_idx_reg == sbmr_pkg::IDX_DEFAULT_TAG[p]) begin
            tag_next[p] = merge(tag_reg[p], w_data_reg, w_strb_reg,
                                sbmr_pkg::TAG_WMASK);
            hit = 1'b1;
          end
          // Counters are read-only; a write is accepted and ignored
          if (aw_idx_reg == sbmr_pkg::IDX_DROP_CNT[p]) begin
            hit = 1'b1;
          end
        end
      end
      bresp_next = hit ? sbmr_pkg::RESP_OKAY : sbmr_pkg::RESP_SLVERR;
    end

    // Drop capture into the first free slot; mask plays no part here
    if (drop_valid) begin
      take_a = !a_valid_next;
      if (take_a) begin
        a_valid_next = 1'b1;
        a_port_next = drop_port;
        a_reason_next = drop_reason;
      end else if (!b_valid_next) begin
        b_valid_next = 1'b1;
        b_port_next = drop_port;
        b_reason_next = drop_reason;
      end
    end

    // Drop counters: a drop in the read cycle survives the clear
    for (int p = 0; p < sbmr_pkg::NUM_PORTS; p++) begin
      if (rd_take && (ar_idx == sbmr_pkg::IDX_DROP_CNT[p])) begin
        cnt_next[p] = (rate_drop && (drop_port == 2'(p))) ?
                      sbmr_pkg::CNT_ONE : sbmr_pkg::CNT_RESET;
      end else if (rate_drop && (drop_port == 2'(p)) &&
                   (cnt_reg[p] != sbmr_pkg::CNT_MAX)) begin
        cnt_next[p] = cnt_reg[p] + sbmr_pkg::CNT_ONE;
      end
    end

    // Read channel
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_take) begin
      rvalid_next = 1'b1;
      rresp_next = sbmr_pkg::RESP_OKAY;
      rdata_next = 32'h0000_0000;
      if (ar_idx == sbmr_pkg::IDX_P2_RATE_Q01) begin
        rdata_next = rate_q01_reg;
      end else if (ar_idx == sbmr_pkg::IDX_P2_RATE_Q23) begin
        rdata_next = rate_q23_reg;
      end else if (ar_idx == sbmr_pkg::IDX_IRQ_MASK) begin
        rdata_next = mask_reg;
      end else if (ar_idx == sbmr_pkg::IDX_IRQ_PENDING) begin
        rdata_next = pend_word;
      end else begin
        rresp_next = sbmr_pkg::RESP_SLVERR;
        for (int p = 0; p < sbmr_pkg::NUM_PORTS; p++) begin
          if (ar_idx == sbmr_pkg::IDX_DEFAULT_TAG[p]) begin
            rdata_next = tag_reg[p];
            rresp_next = sbmr_pkg::RESP_OKAY;
          end
          if (ar_idx == sbmr_pkg::IDX_DROP_CNT[p]) begin
            rdata_next = cnt_reg[p];
            rresp_next = sbmr_pkg::RESP_OKAY;
          end
        end
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_idx_reg <= 14'h0000;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= sbmr_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= sbmr_pkg::RESP_OKAY;
      rate_q01_reg <= sbmr_pkg::RATE_RESET;
      rate_q23_reg <= sbmr_pkg::RATE_RESET;
      mask_reg <= sbmr_pkg::MASK_RESET;
      a_valid_reg <= 1'b0;
      a_port_reg <= 2'h0;
      a_reason_reg <= 4'h0;
      b_valid_reg <= 1'b0;
      b_port_reg <= 2'h0;
      b_reason_reg <= 4'h0;
      for (int p = 0; p < sbmr_pkg::NUM_PORTS; p++) begin
        tag_reg[p] <= sbmr_pkg::TAG_RESET;
        cnt_reg[p] <= sbmr_pkg::CNT_RESET;
      end
    end else begin
      aw_have_reg <= aw_have_next;
      aw_idx_reg <= aw_idx_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      rate_q01_reg <= rate_q01_next;
      rate_q23_reg <= rate_q23_next;
      mask_reg <= mask_next;
      a_valid_reg <= a_valid_next;
      a_port_reg <= a_port_next;
      a_reason_reg <= a_reason_next;
      b_valid_reg <= b_valid_next;
      b_port_reg <= b_port_next;
      b_reason_reg <= b_reason_next;
      for (int p = 0; p < sbmr_pkg::NUM_PORTS; p++) begin
        tag_reg[p] <= tag_next[p];
        cnt_reg[p] <= cnt_next[p];
      end
    end
  end

endmodule

// *** sim/sbmr_monitor.sv ***
`timescale 1ns/1ps
// ************************************************************
// Bus, pacing and interrupt checker
// ************************************************************
module sbmr_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Events, pacing, tags and interrupt
  input wire logic drop_valid,
  input wire logic [3:0] p2_byte_sent,
  input wire logic [3:0] p2_queue_ready,
  input wire logic [11:0] port0_default_vid,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence late_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  wr_answer_a: assert property (both_taken |=> late_answer)
    else $error("write response not two edges after transfer");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one edge after address");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  irq_rise_a: assert property ($rose(irq) |->
    $past(drop_valid) || $past(s_axi_wvalid && s_axi_wready, 2))
    else $error("interrupt rose without event or write");
  irq_fall_a: assert property ($fell(irq) |-> $past(s_axi_wvalid && s_axi_wready, 2))
    else $error("interrupt fell without write");
  pace_q0_a: assert property (p2_byte_sent[0] && p2_queue_ready[0] |=>
    !p2_queue_ready[0])
    else $error("queue 0 not paced after byte");
  pace_q3_a: assert property (p2_byte_sent[3] && p2_queue_ready[3] |=>
    !p2_queue_ready[3])
    else $error("queue 3 not paced after byte");
  tag_move_a: assert property (!$stable(port0_default_vid) |->
    $past(s_axi_wvalid && s_axi_wready, 2))
    else $error("default tag changed without write");
endmodule

bind sbmr_top sbmr_monitor sbmr_monitor_inst (.*);

// *** sim/sbmr_top_test.sv ***
`timescale 1ns/1ps
// ************************************************************
// Register group bench
// ************************************************************
module sbmr_top_test;
  logic aclk, aresetn, irq, drop_valid;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, p2_byte_sent, p2_queue_ready, drop_reason;
  logic [1:0] s_axi_bresp, s_axi_rresp, drop_port, rsp;
  logic [11:0] port0_default_vid, port1_default_vid, port2_default_vid;
  logic [2:0] port0_default_prio, port1_default_prio, port2_default_prio;
  // Back-to-back drop events: ports and reasons, element 0 first
  logic [7:0][1:0] dp_tab = 16'hda90;
  logic [7:0][3:0] dr_tab = 32'h1299_9191;
  logic [2:0][1:0] cnt_tab = 6'b11_01_10;
  int lowc [4] = '{0, 0, 0, 0};
  int n_errors = 0;
  int n_checks = 0;

  sbmr_top sbmr_top_inst (.*);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ************************************************************
  // Compare and closing tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask
  // Flags are combinational, so look mid-cycle once settled
  task automatic chk_flag(input logic [3:0] got, input logic [3:0] exp);
    @(negedge aclk);
    chk({28'h0, got}, {28'h0, exp});
    @(posedge aclk);
  endtask
  task automatic end_sim;
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ************************************************************
  // Bus tasks
  // ************************************************************
  // Ready is sampled at the falling edge; nothing moves before the rising one
  task automatic wr(input logic [13:0] idx, input logic [31:0] d, input logic [3:0] st,
                    output logic [1:0] resp);
    logic a, w, b;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd_reg(input logic [13:0] idx, output logic [31:0] d, output logic [1:0] resp);
    logic a, r;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      a = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
    end while (!r);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rchk(input logic [13:0] idx, input logic [31:0] exp);
    rd_reg(idx, rd, rsp);
    chk(rd, exp);
    chk_resp(rsp, sbmr_pkg::RESP_OKAY);
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100_000;
    n_errors++;
    end_sim();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 68'h0;
    {drop_valid, drop_port, drop_reason, p2_byte_sent} = 11'h000;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_flag({3'h0, irq}, 4'h0);
    for (int i = 0; i < 8; i++) rchk(sbmr_pkg::IDX_P2_RATE_Q01 + 14'(i), 32'h0000_0000);
    rchk(sbmr_pkg::IDX_IRQ_MASK, sbmr_pkg::MASK_RESET);
    // Reserved bits must read back as zero
    for (int i = 0; i < 5; i++) begin
      wr(sbmr_pkg::IDX_P2_RATE_Q01 + 14'(i), 32'hffff_ffff, 4'hf, rsp);
      rchk(sbmr_pkg::IDX_P2_RATE_Q01 + 14'(i),
           (i < 2) ? 32'h03ff_ffff : 32'h0000_7fff);
    end
    wr(sbmr_pkg::IDX_DEFAULT_TAG[1], 32'h0000_2abc, 4'hf, rsp);
    chk({port0_default_prio, port0_default_vid}, 32'h0000_7fff);
    chk({port1_default_prio, port1_default_vid}, 32'h0000_2abc);
    wr(sbmr_pkg::IDX_DEFAULT_TAG[2], 32'h0000_0000, 4'h2, rsp);
    chk({port2_default_prio, port2_default_vid}, 32'h0000_00ff);
    // Pacing: q0=2, q1=0, q2=5, q3=1, low for rate+1 cycles each
    wr(sbmr_pkg::IDX_P2_RATE_Q01, 32'h0000_0002, 4'hf, rsp);
    wr(sbmr_pkg::IDX_P2_RATE_Q23, 32'h0000_2005, 4'hf, rsp);
    chk_flag(p2_queue_ready, 4'hf);
    p2_byte_sent <= 4'hf;
    @(posedge aclk);
    p2_byte_sent <= 4'h0;
    for (int c = 0; c < 10; c++) begin
      @(negedge aclk);
      for (int q = 0; q < 4; q++) lowc[q] += int'(!p2_queue_ready[q]);
    end
    chk({lowc[3][7:0], lowc[2][7:0], lowc[1][7:0], lowc[0][7:0]}, 32'h0206_0103);
    @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      drop_valid <= 1'b1;
      drop_port <= dp_tab[i];
      drop_reason <= dr_tab[i];
      @(posedge aclk);
    end
    drop_valid <= 1'b0;
    chk_flag({3'h0, irq}, 4'h0);
    rchk(sbmr_pkg::IDX_IRQ_PENDING, 32'h0000_2489);
    for (int i = 0; i < 3; i++) begin
      rchk(sbmr_pkg::IDX_DROP_CNT[i], {30'h0, cnt_tab[i]});
      rchk(sbmr_pkg::IDX_DROP_CNT[i], 32'h0000_0000);
    end
    wr(sbmr_pkg::IDX_IRQ_MASK, 32'h0000_0000, 4'hf, rsp);
    chk_flag({3'h0, irq}, 4'h1);
    wr(sbmr_pkg::IDX_IRQ_MASK, 32'h0000_0001, 4'hf, rsp);
    chk_flag({3'h0, irq}, 4'h0);
    wr(sbmr_pkg::IDX_IRQ_MASK, 32'h0000_0000, 4'hf, rsp);
    wr(sbmr_pkg::IDX_IRQ_PENDING, 32'h0000_0001, 4'h1, rsp);
    chk_flag({3'h0, irq}, 4'h1);
    wr(sbmr_pkg::IDX_IRQ_PENDING, 32'h0000_0080, 4'h1, rsp);
    chk_flag({3'h0, irq}, 4'h0);
    // Counters ignore writes; unmapped places answer with an error
    wr(sbmr_pkg::IDX_DROP_CNT[0], 32'h0000_1234, 4'hf, rsp);
    chk_resp(rsp, sbmr_pkg::RESP_OKAY);
    rchk(sbmr_pkg::IDX_DROP_CNT[0], 32'h0000_0000);
    wr(14'h1c19, 32'h0000_0001, 4'hf, rsp);
    chk_resp(rsp, sbmr_pkg::RESP_SLVERR);
    rd_reg(14'h1c19, rd, rsp);
    chk(rd, 32'h0000_0000);
    chk_resp(rsp, sbmr_pkg::RESP_SLVERR);
    // A drop at the edge that takes a counter read survives the clear
    drop_port <= 2'h0;
    drop_reason <= sbmr_pkg::REASON_RED;
    fork
      rchk(sbmr_pkg::IDX_DROP_CNT[0], 32'h0000_0000);
      begin
        drop_valid <= 1'b1;
        @(posedge aclk);
        drop_valid <= 1'b0;
      end
    join
    rchk(sbmr_pkg::IDX_DROP_CNT[0], 32'h0000_0001);
    // Reset in mid-run brings mask and tags back
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_flag({3'h0, irq}, 4'h0);
    rchk(sbmr_pkg::IDX_IRQ_MASK, sbmr_pkg::MASK_RESET);
    rchk(sbmr_pkg::IDX_DEFAULT_TAG[0], 32'h0000_0000);
    end_sim();
  end
endmodule
